// >>> bench/flash_array_model.sv
// Behavioural flash array behind the sequencer: stores page words, fills with ones on erase all.
// Assumes the registered one-cycle strobes of the array command port; no user page is modelled.
`timescale 1ns/1ps
module flash_array_model
(
    input wire logic                         clk_sys,
    input wire flash_seq_pkg::array_cmd_type arrayCmd
);
    import flash_seq_pkg::*;
    logic [31:0] mem [0:4095];
    int          reqCnt = 0;
    always @(posedge clk_sys)
    begin
        if (arrayCmd.eraseAll === 1'b1)
            foreach (mem[i])
                mem[i] = WORD_ERASED;
        if (arrayCmd.req === 1'b1)
        begin
            mem[{arrayCmd.page, arrayCmd.word}] = arrayCmd.data;
            reqCnt++;
        end
    end
endmodule

// >>> bench/flash_page_program_erase_ctrl_tb_top.sv
// Self-checking bench for the flash sequencer: program, locks, key errors and erase all.
// Assumes the package register map and the hand-over timing; one 40 MHz clock.
`timescale 1ns/1ps
module flash_page_program_erase_ctrl_tb_top;
    import flash_seq_pkg::*;
    logic          clk_sys = 1'b0;
    logic          srst = 1'b1;
    reg_req_type   regReq = '0;
    logic          masterSecure = 1'b1;
    logic [15:0]   securePageMask = 16'h0000;
    logic [31:0]   regRdata;
    array_cmd_type arrayCmd;
    logic          volatileClear;
    logic          irq;
    logic          volSeen = 1'b0;
    int            badCount = 0;
    int            nTests = 0;
    int            n;
    logic [31:0]   d;
    initial forever #12.5 clk_sys = ~clk_sys;
    flash_page_program_erase_ctrl dut (.clk_sys(clk_sys), .srst(srst), .regReq(regReq), .masterSecure(masterSecure),
        .securePageMask(securePageMask), .regRdata(regRdata), .arrayCmd(arrayCmd), .volatileClear(volatileClear),
        .irq(irq));
    flash_array_model arr (.clk_sys(clk_sys), .arrayCmd(arrayCmd));
    always @(posedge clk_sys)
        if (volatileClear === 1'b1)
            volSeen <= 1'b1;
    function automatic logic [31:0] cmdWord(input logic [5:0] c, input logic [7:0] p);
        return {CMD_KEY_VALUE, 8'h00, p, 2'h0, c};
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp)
        begin
            badCount++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        regReq.addr  <= a;
        regReq.wdata <= v;
        regReq.wr    <= 1'b1;
        @(posedge clk_sys);
        regReq.wr <= 1'b0;
    endtask
    // Read data only stands one cycle, so it is taken just after that edge
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        regReq.addr <= a;
        regReq.rd   <= 1'b1;
        @(posedge clk_sys);
        regReq.rd <= 1'b0;
        #1 v = regRdata;
    endtask
    task automatic waitReady();
        for (int i = 0; i < 600; i++)
        begin
            rd(OFS_STATUS, d);
            if (d[0] === 1'b1)
                break;
        end
    endtask
    task automatic cmdStatus(input logic [31:0] c, input logic [31:0] exp, input string what);
        wr(OFS_CMD, c);
        repeat (4) @(posedge clk_sys);
        rd(OFS_STATUS, d);
        chk(what, d, exp);
    endtask
    task automatic tReset();
        rd(OFS_STATUS, d);
        chk("reset status", d, 32'h0000_0011);
        rd(OFS_FUSE, d);
        chk("reset fuse", d, 32'hFFFF_0007);
        rd(12'h100, d);
        chk("unmapped read", d, 32'h0000_0000);
    endtask
    task automatic tProgram();
        wr(OFS_CTRL, 32'h0000_0001);
        wr(OFS_CMD, cmdWord(CMD_CLR_BUF, 8'h80));
        for (int i = 0; i < 16; i++)
            wr(OFS_BUF + 12'(4 * i), 32'hC0DE_0000 + 32'(i));
        wr(OFS_BUF + 12'h054, 32'hBEEF_0005);
        rd(OFS_CMD, d);
        chk("page from buffer", d, 32'h0000_2103);
        wr(OFS_CMD, cmdWord(CMD_WRITE_PG, 8'h80));
        rd(OFS_STATUS, d);
        chk("busy status", d, 32'h0000_0010);
        waitReady();
        chk("done status", d, 32'h0000_0011);
        chk("ready irq", {31'h0, irq}, 32'h1);
        for (int i = 0; i < 16; i++)
            chk("page word", arr.mem[{8'h80, 4'(i)}], i == 5 ? 32'hBEEF_0005 : 32'hC0DE_0000 + 32'(i));
        wr(OFS_CTRL, 32'h0000_0000);
        repeat (3) @(posedge clk_sys);
        chk("irq off", {31'h0, irq}, 32'h0);
    endtask
    task automatic tLocks();
        wr(OFS_CTRL, 32'h0000_0004);
        n = arr.reqCnt;
        wr(OFS_CMD, cmdWord(CMD_WRITE_PG, 8'h10));
        repeat (4) @(posedge clk_sys);
        chk("lock irq", {31'h0, irq}, 32'h1);
        rd(OFS_STATUS, d);
        chk("boot lock", d, 32'h0000_0015);
        wr(OFS_CMD, cmdWord(CMD_LOCK_RG, 8'h90));
        rd(OFS_LOCK, d);
        chk("region lock", d & 32'h0000_0200, 32'h0000_0200);
        cmdStatus(cmdWord(CMD_WRITE_PG, 8'h9F), 32'h0000_0015, "locked page");
        wr(OFS_CMD, cmdWord(CMD_UNLOCK_RG, 8'h90));
        @(posedge clk_sys);
        securePageMask <= 16'h0100;
        masterSecure   <= 1'b0;
        cmdStatus(cmdWord(CMD_WRITE_PG, 8'h80), 32'h0000_0015, "secure page");
        chk("no array write", 32'(arr.reqCnt), 32'(n));
        @(posedge clk_sys);
        masterSecure   <= 1'b1;
        securePageMask <= 16'h0000;
        wr(OFS_CTRL, 32'h0000_0000);
    endtask
    task automatic tErrors();
        cmdStatus({8'h5A, 8'h00, 8'h80, 2'h0, CMD_WRITE_PG}, 32'h0000_0019, "bad key");
        cmdStatus(cmdWord(6'h3F, 8'h80), 32'h0000_0019, "bad code");
    endtask
    task automatic tEraseAll();
        cmdStatus(cmdWord(CMD_ERASE_ALL, 8'h00), 32'h0000_0015, "guarded erase");
        chk("no clear", {31'h0, volSeen}, 32'h0);
        wr(OFS_FUSE, 32'h0000_0000);
        rd(OFS_FUSE, d);
        chk("fuse write", d, 32'h0000_0000);
        wr(OFS_CMD, cmdWord(CMD_ERASE_ALL, 8'h00));
        waitReady();
        chk("erase status", d, 32'h0000_0011);
        chk("volatile clear", {31'h0, volSeen}, 32'h1);
        rd(OFS_FUSE, d);
        chk("erased fuse", d, 32'hFFFF_0000);
        chk("erased word", arr.mem[12'h800], WORD_ERASED);
    endtask
    task automatic finishTest();
        $display("checks %0d mismatches %0d", nTests, badCount);
        if (badCount == 0 && nTests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        tReset();
        tProgram();
        tLocks();
        tErrors();
        tEraseAll();
        finishTest();
    end
    // Whole run needs a little over a thousand cycles; the ceiling leaves wide margin
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        badCount++;
        finishTest();
    end
endmodule

// >>> bench/flash_seq_props.sv
// Checker for the flash sequencer: command to array timing, erase all and volatile clear cause, interrupt gating.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module flash_seq_props
(
    input wire logic                         clk_sys,
    input wire logic                         srst,
    input wire flash_seq_pkg::reg_req_type   regReq,
    input wire logic                         masterSecure,
    input wire logic [15:0]                  securePageMask,
    input wire logic [31:0]                  regRdata,
    input wire flash_seq_pkg::array_cmd_type arrayCmd,
    input wire logic                         volatileClear,
    input wire logic                         irq
);
    import flash_seq_pkg::*;
    logic [3:0] progAge_ff;
    logic [3:0] eraseAge_ff;
    logic [3:0] ctrlCopy_ff;
    logic       keyedWr;
    // Ages saturate so a stale command can never excuse a late start
    assign keyedWr = regReq.wr && regReq.addr == OFS_CMD && regReq.wdata[31:24] == CMD_KEY_VALUE;
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            progAge_ff  <= 4'hF;
            eraseAge_ff <= 4'hF;
            ctrlCopy_ff <= 4'h0;
        end
        else
        begin
            progAge_ff  <= (keyedWr && regReq.wdata[5:0] == CMD_WRITE_PG) ? 4'h0 :
                           (progAge_ff == 4'hF ? 4'hF : progAge_ff + 4'h1);
            eraseAge_ff <= (keyedWr && regReq.wdata[5:0] == CMD_ERASE_ALL) ? 4'h0 :
                           (eraseAge_ff == 4'hF ? 4'hF : eraseAge_ff + 4'h1);
            if (regReq.wr && regReq.addr == OFS_CTRL)
                ctrlCopy_ff <= regReq.wdata[3:0];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    property p_req_cause;
        $rose(arrayCmd.req) |-> progAge_ff <= 4'h4 && arrayCmd.word == 4'h0;
    endproperty
    a_req_cause: assert property (p_req_cause) else $error("array write without program command");
    property p_req_burst;
        $rose(arrayCmd.req) |-> arrayCmd.req[*8] ##1 arrayCmd.req[*8] ##1 !arrayCmd.req;
    endproperty
    a_req_burst: assert property (p_req_burst) else $error("page burst not sixteen words");
    property p_word_step;
        arrayCmd.req && $past(arrayCmd.req) |-> arrayCmd.word == $past(arrayCmd.word) + 4'h1;
    endproperty
    a_word_step: assert property (p_word_step) else $error("buffer word order broken");
    property p_page_hold;
        arrayCmd.req && $past(arrayCmd.req) |-> $stable(arrayCmd.page);
    endproperty
    a_page_hold: assert property (p_page_hold) else $error("target page moved in burst");
    property p_ea_cause;
        arrayCmd.eraseAll |-> eraseAge_ff <= 4'h4 && !arrayCmd.req;
    endproperty
    a_ea_cause: assert property (p_ea_cause) else $error("erase all without command");
    property p_vol_pulse;
        volatileClear |-> eraseAge_ff <= 4'h4 ##1 !volatileClear;
    endproperty
    a_vol_pulse: assert property (p_vol_pulse) else $error("volatile clear out of place");
    property p_irq_gate;
        irq |-> ctrlCopy_ff != 4'h0 || $past(ctrlCopy_ff) != 4'h0 || $past(ctrlCopy_ff, 2) != 4'h0;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt with no enable");
    property p_irq_reset;
        $fell(srst) |-> !irq;
    endproperty
    a_irq_reset: assert property (p_irq_reset) else $error("interrupt right after reset");
endmodule
bind flash_page_program_erase_ctrl flash_seq_props u_props (.clk_sys(clk_sys), .srst(srst), .regReq(regReq),
    .masterSecure(masterSecure), .securePageMask(securePageMask), .regRdata(regRdata), .arrayCmd(arrayCmd),
    .volatileClear(volatileClear), .irq(irq));

// >>> hdl/flash_page_program_erase_ctrl.sv
// Flash command sequencer: page buffer, keyed commands, locks, erase all and interrupts.
// Assumes one 40 MHz clock, synchronous reset and a master that never holds both strobes.
`timescale 1ns/1ps
module flash_page_program_erase_ctrl
(
    input  wire logic                        clk_sys,
    input  wire logic                        srst,
    input  wire flash_seq_pkg::reg_req_type  regReq,
    input  wire logic                        masterSecure,
    input  wire logic [15:0]                 securePageMask,
    output logic [31:0]                      regRdata,
    output flash_seq_pkg::array_cmd_type     arrayCmd,
    output logic                             volatileClear,
    output logic                             irq
);
    import flash_seq_pkg::*;

    typedef struct packed
    {
        seq_state_type     state;
        logic [CNT_W-1:0]  cnt;
        logic [BUF_AW:0]   idx;
        logic [31:0]       rdata;
        logic [3:0]        ctrl;
        logic [PAGE_W-1:0] page;
        logic [5:0]        cmd;
        logic              rdy;
        logic              lockErr;
        logic              progErr;
        logic              secBit;
        logic [REGION_CNT-1:0] lock;
        logic [2:0]        bootSize;
        logic [15:0]       gpFuse;
        logic [3:0]        intMask;
        array_cmd_type     arr;
        logic              volClr;
        logic              irq;
    } state_type;

    state_type cur_ff;
    state_type nxt_cur;
    logic [31:0] pageBuf [BUF_WORDS];

    logic              cmdWr;
    logic              bufWr;
    logic [7:0]        cmdKey;
    logic [5:0]        cmdCode;
    logic [PAGE_W-1:0] cmdPage;
    logic              tgtLocked;
    logic              tgtSecure;
    logic [3:0]        evt;

    assign cmdWr   = regReq.wr && regReq.addr == OFS_CMD;
    assign bufWr   = regReq.wr && regReq.addr >= OFS_BUF;
    assign cmdKey  = regReq.wdata[CMD_KEY_LSB +: 8];
    assign cmdCode = regReq.wdata[CMD_CODE_LSB +: 6];
    assign cmdPage = regReq.wdata[CMD_PAGE_LSB +: PAGE_W];
    // Region granularity: one lock bit per REGION_SH-bit group of pages
    assign tgtLocked = cur_ff.lock[cmdPage[PAGE_W-1 -: 4]]
                     || (cmdPage[PAGE_W-1 -: 4] < {1'b0, cur_ff.bootSize});
    assign tgtSecure = securePageMask[cmdPage[PAGE_W-1 -: 4]] && !masterSecure;

    // Word-only buffer writes are assumed; the port has no byte lanes
    always_ff @(posedge clk_sys)
    begin
        if (bufWr)
        begin
            pageBuf[regReq.addr[BUF_AW+1:2]] <= regReq.wdata;
        end
        else if (cur_ff.state == ST_IDLE && cmdWr && cmdKey == CMD_KEY_VALUE && cmdCode == CMD_CLR_BUF)
        begin
            for (int i = 0; i < BUF_WORDS; i++)
            begin
                pageBuf[i] <= WORD_ERASED;
            end
        end
    end

    always_comb
    begin
        nxt_cur = cur_ff;
        evt = 4'h0;
        nxt_cur.arr.req = 1'b0;
        nxt_cur.arr.erase = 1'b0;
        nxt_cur.arr.eraseAll = 1'b0;
        nxt_cur.volClr = 1'b0;
        nxt_cur.rdata = 32'h00000000;

        if (bufWr)
        begin
            // The byte address only reaches bit 11, so the upper page bits read as zero
            nxt_cur.page = PAGE_W'(regReq.addr[ADDR_W-1:BUF_AW+2]);
        end

        case (cur_ff.state)
            ST_IDLE:
            begin
                nxt_cur.rdy = 1'b1;
                if (cmdWr)
                begin
                    nxt_cur.page = cmdPage;
                    if (cmdKey != CMD_KEY_VALUE)
                    begin
                        evt[ST_PERR] = 1'b1;
                    end
                    else
                    begin
                        case (cmdCode)
                            CMD_WRITE_PG:
                            begin
                                if (tgtLocked || tgtSecure)
                                begin
                                    evt[ST_LOCK] = 1'b1;
                                end
                                else
                                begin
                                    nxt_cur.state = ST_PROG;
                                    nxt_cur.rdy = 1'b0;
                                    nxt_cur.cnt = '0;
                                    nxt_cur.idx = '0;
                                end
                            end
                            CMD_ERASE_ALL:
                            begin
                                if (cur_ff.lock != LOCK_RESET || cur_ff.bootSize != 3'h0)
                                begin
                                    evt[ST_LOCK] = 1'b1;
                                end
                                else
                                begin
                                    nxt_cur.state = ST_EA_VOL;
                                    nxt_cur.rdy = 1'b0;
                                    nxt_cur.cnt = '0;
                                end
                            end
                            CMD_LOCK_RG:
                            begin
                                nxt_cur.lock[cmdPage[PAGE_W-1 -: 4]] = 1'b1;
                            end
                            CMD_UNLOCK_RG:
                            begin
                                nxt_cur.lock[cmdPage[PAGE_W-1 -: 4]] = 1'b0;
                            end
                            CMD_CLR_BUF, CMD_NOP:
                            begin
                            end
                            default:
                            begin
                                evt[ST_PERR] = 1'b1;
                            end
                        endcase
                    end
                end
            end
            ST_PROG:
            begin
                if (cur_ff.idx < (BUF_AW+1)'(BUF_WORDS))
                begin
                    nxt_cur.arr.req = 1'b1;
                    nxt_cur.arr.page = cur_ff.page;
                    nxt_cur.arr.word = cur_ff.idx[BUF_AW-1:0];
                    nxt_cur.arr.data = pageBuf[cur_ff.idx[BUF_AW-1:0]];
                    nxt_cur.idx = cur_ff.idx + 1'b1;
                end
                nxt_cur.cnt = cur_ff.cnt + 1'b1;
                if (cur_ff.cnt == CNT_W'(PROG_CYCLES - 1))
                begin
                    nxt_cur.state = ST_IDLE;
                    nxt_cur.rdy = 1'b1;
                    evt[ST_RDY] = 1'b1;
                end
            end
            ST_EA_VOL:
            begin
                // Volatile state goes first so secrets never outlive the security bit
                nxt_cur.volClr = 1'b1;
                nxt_cur.state = ST_EA_ARR;
            end
            ST_EA_ARR:
            begin
                // No word write beside the erase pulse, or stale data would land after it
                nxt_cur.arr.eraseAll = cur_ff.cnt == '0;
                nxt_cur.cnt = cur_ff.cnt + 1'b1;
                if (cur_ff.cnt == CNT_W'(ERASE_CYCLES - 1))
                begin
                    nxt_cur.gpFuse = GP_FUSE_ERASED;
                    nxt_cur.state = ST_EA_SEC;
                end
            end
            ST_EA_SEC:
            begin
                nxt_cur.secBit = 1'b1;
                nxt_cur.state = ST_IDLE;
                nxt_cur.rdy = 1'b1;
                evt[ST_RDY] = 1'b1;
            end
            default:
            begin
                nxt_cur.state = ST_IDLE;
            end
        endcase

        if (regReq.wr && regReq.addr == OFS_CTRL)
        begin
            nxt_cur.ctrl = regReq.wdata[3:0];
        end
        if (regReq.wr && regReq.addr == OFS_INTMASK)
        begin
            nxt_cur.intMask = regReq.wdata[3:0];
        end
        if (regReq.wr && regReq.addr == OFS_FUSE && cur_ff.state == ST_IDLE)
        begin
            nxt_cur.bootSize = regReq.wdata[2:0];
            nxt_cur.gpFuse = regReq.wdata[31:16];
        end

        if (regReq.rd)
        begin
            case (regReq.addr)
                OFS_CTRL:    nxt_cur.rdata = {28'h0, cur_ff.ctrl};
                OFS_CMD:     nxt_cur.rdata = {16'h0, cur_ff.page, 2'h0, cur_ff.cmd};
                OFS_STATUS:  nxt_cur.rdata = {27'h0, cur_ff.secBit, cur_ff.progErr, cur_ff.lockErr,
                                              1'b0, cur_ff.rdy};
                OFS_LOCK:    nxt_cur.rdata = {16'h0, cur_ff.lock};
                OFS_FUSE:    nxt_cur.rdata = {cur_ff.gpFuse, 13'h0, cur_ff.bootSize};
                OFS_INTMASK: nxt_cur.rdata = {28'h0, cur_ff.intMask};
                default:     nxt_cur.rdata = 32'h00000000;
            endcase
        end
        if (cmdWr)
        begin
            nxt_cur.cmd = cmdCode;
        end

        // Status read clears sticky errors; a same-cycle event still wins
        if (regReq.rd && regReq.addr == OFS_STATUS)
        begin
            nxt_cur.lockErr = 1'b0;
            nxt_cur.progErr = 1'b0;
        end
        if (evt[ST_LOCK])
        begin
            nxt_cur.lockErr = 1'b1;
        end
        if (evt[ST_PERR])
        begin
            nxt_cur.progErr = 1'b1;
        end

        nxt_cur.irq = (cur_ff.ctrl[CTRL_RDY_IE] && nxt_cur.rdy && cur_ff.intMask[ST_RDY])
                    || (cur_ff.ctrl[CTRL_LOCK_IE] && nxt_cur.lockErr && cur_ff.intMask[ST_LOCK])
                    || (cur_ff.ctrl[CTRL_PERR_IE] && nxt_cur.progErr && cur_ff.intMask[ST_PERR]);

        if (srst)
        begin
            nxt_cur = '0;
            nxt_cur.state = ST_IDLE;
            nxt_cur.rdy = 1'b1;
            nxt_cur.secBit = 1'b1;
            nxt_cur.bootSize = BOOT_FUSE_RESET;
            nxt_cur.gpFuse = GP_FUSE_ERASED;
            nxt_cur.lock = LOCK_RESET;
            nxt_cur.intMask = 4'hF;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        cur_ff <= nxt_cur;
    end

    assign regRdata = cur_ff.rdata;
    assign arrayCmd = cur_ff.arr;
    assign volatileClear = cur_ff.volClr;
    assign irq = cur_ff.irq;
endmodule

// >>> hdl/flash_seq_pkg.sv
// Package for the flash program and erase sequencer: offsets, fields, commands, states.
// Assumes a single 40 MHz system clock and a plain one-cycle strobe register port.
package flash_seq_pkg;

    localparam int ADDR_W      = 12;
    localparam int BUF_WORDS   = 16;
    localparam int BUF_AW      = 4;
    localparam int PAGE_W      = 8;
    localparam int REGION_CNT  = 16;
    localparam int REGION_SH   = 4;

    // Byte address of each register (the word index is a quarter of it)
    localparam logic [ADDR_W-1:0] OFS_CTRL    = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_CMD     = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_LOCK    = 12'h00C;
    localparam logic [ADDR_W-1:0] OFS_FUSE    = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_INTMASK = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_BUF     = 12'h800;

    // Control register fields
    localparam int CTRL_RDY_IE  = 0;
    localparam int CTRL_LOCK_IE = 2;
    localparam int CTRL_PERR_IE = 3;

    // Status register fields
    localparam int ST_RDY  = 0;
    localparam int ST_LOCK = 2;
    localparam int ST_PERR = 3;
    localparam int ST_SEC  = 4;

    // Command register fields
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_PAGE_LSB = 8;
    localparam int CMD_KEY_LSB  = 24;
    localparam logic [7:0] CMD_KEY_VALUE = 8'hA5;

    localparam logic [5:0] CMD_NOP      = 6'h00;
    localparam logic [5:0] CMD_WRITE_PG = 6'h01;
    localparam logic [5:0] CMD_ERASE_ALL = 6'h08;
    localparam logic [5:0] CMD_LOCK_RG  = 6'h04;
    localparam logic [5:0] CMD_UNLOCK_RG = 6'h05;
    localparam logic [5:0] CMD_CLR_BUF  = 6'h03;

    localparam logic [2:0]  BOOT_FUSE_RESET = 3'h7;
    localparam logic [15:0] LOCK_RESET      = 16'h0000;
    localparam logic [15:0] GP_FUSE_ERASED  = 16'hFFFF;
    localparam logic [31:0] WORD_ERASED     = 32'hFFFFFFFF;

    // Timing
    localparam int CLK_MHZ       = 40;
    localparam int PROG_TIME_US  = 5;
    localparam int PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_TIME_US = 20;
    localparam int ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;
    localparam int CNT_W         = 12;

    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b000,
        ST_PROG   = 3'b001,
        ST_EA_VOL = 3'b010,
        ST_EA_ARR = 3'b011,
        ST_EA_SEC = 3'b100
    } seq_state_type;

    typedef struct packed
    {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } reg_req_type;

    typedef struct packed
    {
        logic              req;
        logic              erase;
        logic              eraseAll;
        logic [PAGE_W-1:0] page;
        logic [31:0]       data;
        logic [BUF_AW-1:0] word;
    } array_cmd_type;

endpackage
